// ---- design/async_tx_byte_counter.sv ----
`timescale 1ns/1ns
`include "async_tx_regs.svh"

module async_tx_byte_counter (
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic clear_i,
	input wire logic add_i,
	output logic [11:0] count_o
);

	// Bytes of the current packet, restarted by its first quadlet; saturates so huge packets never wrap
	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
			count_o <= 12'h000;
		else if (add_i && clear_i)
			count_o <= `AT_QUADLET_BYTES;
		else if (add_i && count_o <= (`AT_COUNT_MAX - `AT_QUADLET_BYTES))
			count_o <= count_o + `AT_QUADLET_BYTES;
		else if (add_i)
			count_o <= `AT_COUNT_MAX;
	end

endmodule

// ---- design/async_tx_pkg.sv ----
package async_tx_pkg;

	// Threshold select field encodings, in field order
	typedef enum logic [1:0] {THRESH_SAF, THRESH_1K7, THRESH_1K, THRESH_512} thresh_sel_t;

	// Transmit sequencer states
	typedef enum logic [1:0] {ST_IDLE, ST_FILL, ST_SEND} tx_state_t;

	// Register access request, config or memory space
	typedef struct packed {
		logic wr;
		logic rd;
		logic mem_space;
		logic [11:0] addr;
		logic [31:0] wdata;
	} reg_req_t;

	// Quadlet checked into the transmit FIFO by DMA
	typedef struct packed {
		logic valid;
		logic sop;
		logic eop;
	} fill_t;

	// Link side view of the FIFO
	typedef struct packed {
		logic fifo_empty;
		logic done;
	} drain_t;

endpackage

// ---- design/async_tx_regs.svh ----
`ifndef ASYNC_TX_REGS_SVH
`define ASYNC_TX_REGS_SVH

// Register locations
`define LEC_CFG_OFFSET 12'h0F4
`define LEC_SET_OFFSET 12'h088
`define LEC_CLR_OFFSET 12'h08C

// Storage layout
`define LEC_RESET 32'h00001000
`define LEC_WRITE_MASK 32'h0000F000
`define LEC_THRESH_MASK 32'h00003000
`define LEC_EEPROM_MASK 32'h0000F000
`define LEC_REORDER_BIT 15
`define LEC_SPARE_BIT 14
`define LEC_THRESH_HI 13
`define LEC_THRESH_LO 12

// Thresholds, quadlet size and count ceiling in bytes
`define AT_THRESH_2K 12'h800
`define AT_THRESH_1K7 12'h6C0
`define AT_THRESH_1K 12'h400
`define AT_THRESH_512 12'h200
`define AT_QUADLET_BYTES 12'h004
`define AT_COUNT_MAX 12'hFFF

`endif

// ---- design/async_tx_threshold_control.sv ----
`timescale 1ns/1ns
`include "async_tx_regs.svh"

module async_tx_threshold_control (
	input wire logic clock_i,
	input wire logic rst_i,
	input wire async_tx_pkg::reg_req_t reg_req_i,
	output logic [31:0] reg_rdata_o,
	output logic reg_rvalid_o,
	input wire logic eeprom_load_i,
	input wire logic [31:0] eeprom_data_i,
	input wire logic [3:0] retry_limit_i,
	input wire logic retry_i,
	input wire async_tx_pkg::fill_t fill_i,
	input wire async_tx_pkg::drain_t drain_i,
	output logic tx_start_o,
	output logic tx_underrun_o,
	output logic saf_active_o,
	output logic tx_reorder_disable_o,
	output logic [11:0] tx_threshold_o
);
	import async_tx_pkg::*;

	logic [31:0] lec_reg;
	logic [31:0] lec_next;
	logic cfg_hit;
	logic set_hit;
	logic clr_hit;
	logic any_hit;
	logic thresh_written;
	logic fallback_reg;
	logic pkt_retry_reg;
	logic pkt_complete_reg;
	logic [11:0] byte_count;
	logic [11:0] thresh_bytes;
	thresh_sel_t thresh_sel;
	logic saf_now;
	logic start_cond;
	logic underrun_now;
	logic new_packet;
	tx_state_t state_reg;
	tx_state_t state_next;

	// Address decode of the three views of one register
	assign cfg_hit = !reg_req_i.mem_space && reg_req_i.addr == `LEC_CFG_OFFSET;
	assign set_hit = reg_req_i.mem_space && reg_req_i.addr == `LEC_SET_OFFSET;
	assign clr_hit = reg_req_i.mem_space && reg_req_i.addr == `LEC_CLR_OFFSET;
	assign any_hit = cfg_hit || set_hit || clr_hit;

	// Next register value; EEPROM load yields to a config write in the same cycle, set and clear writes apply on top of it
	always_comb
	begin
		lec_next = lec_reg;
		if (eeprom_load_i)
			lec_next = (lec_reg & ~`LEC_EEPROM_MASK) | (eeprom_data_i & `LEC_EEPROM_MASK);
		if (reg_req_i.wr && cfg_hit)
			lec_next = reg_req_i.wdata & `LEC_WRITE_MASK;
		else if (reg_req_i.wr && set_hit)
			lec_next = lec_next | (reg_req_i.wdata & `LEC_WRITE_MASK);
		else if (reg_req_i.wr && clr_hit)
			lec_next = lec_next & ~(reg_req_i.wdata & `LEC_WRITE_MASK);
		lec_next = lec_next & `LEC_WRITE_MASK;
	end

	// Enhancement storage; spare bit 14 is kept but steers nothing
	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
			lec_reg <= `LEC_RESET;
		else
			lec_reg <= lec_next;
	end

	// Registered read port, unmapped addresses read zero
	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			reg_rdata_o <= 32'h00000000;
			reg_rvalid_o <= 1'b0;
		end
		else
		begin
			reg_rvalid_o <= reg_req_i.rd;
			if (reg_req_i.rd && any_hit)
				reg_rdata_o <= lec_reg & `LEC_WRITE_MASK;
			else
				reg_rdata_o <= 32'h00000000;
		end
	end

	// Pipelining control registered from storage, one cycle behind it
	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
			tx_reorder_disable_o <= 1'b0;
		else
			tx_reorder_disable_o <= lec_reg[`LEC_REORDER_BIT];
	end

	// A threshold touch re-arms the programmed value after a fallback
	assign thresh_written = reg_req_i.wr && (cfg_hit || ((set_hit || clr_hit) &&
		(reg_req_i.wdata & `LEC_THRESH_MASK) != 32'h00000000));

	// Sticky store-and-forward after an underrun; a new underrun wins over re-arming
	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
			fallback_reg <= 1'b0;
		else if (underrun_now)
			fallback_reg <= 1'b1;
		else if (thresh_written)
			fallback_reg <= 1'b0;
	end

	// Per packet bookkeeping, one packet in flight at a time
	assign new_packet = fill_i.valid && fill_i.sop && state_reg == ST_IDLE;

	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
			pkt_retry_reg <= 1'b0;
		else if (new_packet)
			pkt_retry_reg <= retry_i;
	end

	// Whole packet checked in; the end mark of the same quadlet wins over the restart
	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
			pkt_complete_reg <= 1'b0;
		else if (fill_i.valid && fill_i.eop)
			pkt_complete_reg <= 1'b1;
		else if (new_packet)
			pkt_complete_reg <= 1'b0;
	end

	// Byte count of the current packet
	async_tx_byte_counter u_count (
		.clock_i(clock_i),
		.rst_i(rst_i),
		.clear_i(new_packet),
		.add_i(fill_i.valid),
		.count_o(byte_count)
	);

	// Effective threshold: any store-and-forward cause forces the 2K value
	assign thresh_sel = thresh_sel_t'(lec_reg[`LEC_THRESH_HI:`LEC_THRESH_LO]);
	assign saf_now = thresh_sel == THRESH_SAF || fallback_reg || pkt_retry_reg || retry_limit_i == 4'h0;

	always_comb
	begin
		thresh_bytes = `AT_THRESH_2K;
		if (!saf_now)
		begin
			case (thresh_sel)
				THRESH_1K7: thresh_bytes = `AT_THRESH_1K7;
				THRESH_1K: thresh_bytes = `AT_THRESH_1K;
				THRESH_512: thresh_bytes = `AT_THRESH_512;
				default: thresh_bytes = `AT_THRESH_2K;
			endcase
		end
	end

	// Start on threshold, or once the packet is complete; store-and-forward only the latter
	assign start_cond = state_reg == ST_FILL && (pkt_complete_reg || (!saf_now && byte_count >= thresh_bytes));
	// FIFO ran dry before the packet end was checked in
	assign underrun_now = state_reg == ST_SEND && !drain_i.done && drain_i.fifo_empty && !pkt_complete_reg;

	// Sequencer next state
	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE:
				if (new_packet)
					state_next = ST_FILL;
			ST_FILL:
				if (start_cond)
					state_next = ST_SEND;
			ST_SEND:
				if (drain_i.done || underrun_now)
					state_next = ST_IDLE;
			default:
				state_next = ST_IDLE;
		endcase
	end

	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
			state_reg <= ST_IDLE;
		else
			state_reg <= state_next;
	end

	// Event pulses toward the link
	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			tx_start_o <= 1'b0;
			tx_underrun_o <= 1'b0;
		end
		else
		begin
			tx_start_o <= start_cond;
			tx_underrun_o <= underrun_now;
		end
	end

	// Status view of the active mode
	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			saf_active_o <= 1'b0;
			tx_threshold_o <= `AT_THRESH_1K7;
		end
		else
		begin
			saf_active_o <= saf_now;
			tx_threshold_o <= thresh_bytes;
		end
	end

	// Checks on the behaviour above
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (rst_i);

	sequence s_clear_thresh_hi;
		reg_req_i.wr && clr_hit && reg_req_i.wdata[`LEC_THRESH_HI] && !eeprom_load_i;
	endsequence

	sequence s_cfg_read_only;
		reg_req_i.rd && !reg_req_i.wr && cfg_hit && !eeprom_load_i;
	endsequence

	sequence s_set_reorder;
		reg_req_i.wr && set_hit && reg_req_i.wdata[`LEC_REORDER_BIT];
	endsequence

	sequence s_retry_packet;
		new_packet && retry_i && !(fill_i.eop);
	endsequence

	sequence s_bus_quiet;
		!reg_req_i.wr && !eeprom_load_i;
	endsequence

	sequence s_clear_reorder;
		reg_req_i.wr && clr_hit && reg_req_i.wdata[`LEC_REORDER_BIT];
	endsequence

	AST_THRESH_512: assert property (!saf_now && thresh_sel == THRESH_512 |=> tx_threshold_o == 12'h200)
		else $error("512 byte threshold not applied");

	AST_FALLBACK_STICKY: assert property (underrun_now |=> fallback_reg ##1 saf_active_o && tx_threshold_o == 12'h800)
		else $error("underrun did not force store and forward");

	AST_RETRY_WAITS: assert property (s_retry_packet ##1 (!pkt_complete_reg && !(fill_i.valid && fill_i.eop))
		|=> !tx_start_o)
		else $error("retried packet started before completion");

	AST_EARLY_START: assert property (state_reg == ST_FILL && pkt_complete_reg |=> tx_start_o ##1 state_reg == ST_SEND)
		else $error("complete packet did not start");

	AST_THRESH_START: assert property (state_reg == ST_FILL && !saf_now && byte_count >= thresh_bytes |=> tx_start_o)
		else $error("threshold reached without start");

	AST_UNDERRUN: assert property (state_reg == ST_SEND && drain_i.fifo_empty && !drain_i.done && !pkt_complete_reg
		|=> tx_underrun_o && state_reg == ST_IDLE)
		else $error("underrun not flagged");

	AST_REORDER: assert property (s_set_reorder |-> ##2 tx_reorder_disable_o)
		else $error("pipelining disable not applied");

	AST_UPPER_ZERO: assert property (reg_rvalid_o |-> reg_rdata_o[31:16] == 16'h0000)
		else $error("upper bits read nonzero");

	AST_ALIAS: assert property (s_clear_thresh_hi ##1 s_bus_quiet ##1 s_cfg_read_only
		|=> reg_rvalid_o && !reg_rdata_o[`LEC_THRESH_HI])
		else $error("clear alias not seen in config view");

	AST_EEPROM: assert property (eeprom_load_i && !reg_req_i.wr |=> lec_reg[`LEC_REORDER_BIT] == $past(eeprom_data_i[15]))
		else $error("eeprom bit not loaded");

	AST_NO_RETRIES: assert property (retry_limit_i == 4'h0 && state_reg == ST_FILL && !pkt_complete_reg |=> !tx_start_o)
		else $error("started early with zero retry count");

	AST_COUNT_CLEAR: assert property (new_packet |=> byte_count == 12'h004)
		else $error("byte count not restarted");

	// Whole fill phase of a retried packet, not just its first cycle
	AST_RETRY_HOLD: assert property (state_reg == ST_FILL && pkt_retry_reg && !pkt_complete_reg |=> !tx_start_o)
		else $error("retried packet started while incomplete");

	AST_REORDER_CLEAR: assert property (s_clear_reorder |-> ##2 !tx_reorder_disable_o)
		else $error("pipelining disable not cleared");

	AST_START_PULSE: assert property (tx_start_o |=> !tx_start_o)
		else $error("start held longer than one cycle");

	AST_RVALID: assert property (reg_req_i.rd |=> reg_rvalid_o)
		else $error("read not answered");

	AST_SAF_ZERO_RETRY: assert property (retry_limit_i == 4'h0 |=> saf_active_o && tx_threshold_o == 12'h800)
		else $error("zero retry count did not force store and forward");

endmodule

// ---- test/fifo_side_model.sv ----
`timescale 1ns/1ns
module fifo_side_model (
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic go_i,
	input wire logic [11:0] quads_i,
	input wire logic [11:0] starve_i,
	input wire logic tx_start_i,
	input wire logic tx_underrun_i,
	output async_tx_pkg::fill_t fill_o,
	output async_tx_pkg::drain_t drain_o,
	output logic [11:0] sent_o
);
	import async_tx_pkg::*;
	logic [11:0] left;
	logic [11:0] level;
	logic sending;
	logic done_reg;

	// DMA side: one quadlet a cycle; stalls for good at starve_i so the FIFO can run dry
	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			fill_o <= '0;
			left <= '0;
			sent_o <= '0;
		end
		else if (go_i)
		begin
			left <= quads_i;
			sent_o <= '0;
		end
		else
		begin
			fill_o <= '0;
			if (left != 12'h000 && sent_o != starve_i)
			begin
				fill_o <= '{valid: 1'h1, sop: sent_o == 12'h000, eop: left == 12'h001};
				left <= left - 12'h001;
				sent_o <= sent_o + 12'h001;
			end
		end
	end

	// Link side: drains a quadlet a cycle after start, as fast as DMA fills, so only a stall empties it
	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			level <= '0;
			sending <= 1'h0;
			done_reg <= 1'h0;
		end
		else
		begin
			level <= level + {11'h000, fill_o.valid} - {11'h000, sending && level != 12'h000};
			done_reg <= sending && left == 12'h000 && level == 12'h000 && !fill_o.valid && !done_reg;
			if (tx_start_i)
				sending <= 1'h1;
			else if (tx_underrun_i || done_reg)
				sending <= 1'h0;
		end
	end

	// Empty flag straight from occupancy
	assign drain_o = '{fifo_empty: level == 12'h000, done: done_reg};
endmodule

// ---- test/tb_async_tx_threshold_control.sv ----
`timescale 1ns/1ns
module tb_async_tx_threshold_control;
	import async_tx_pkg::*;
	logic clock_i = 1'h0;
	logic rst_i = 1'h1;
	logic go = 1'h0;
	logic eeprom_load_i = 1'h0;
	logic retry_i = 1'h0;
	reg_req_t reg_req_i = '0;
	logic [31:0] eeprom_data_i = '0;
	logic [31:0] rd;
	logic [31:0] reg_rdata_o;
	logic [3:0] retry_limit_i = 4'h1;
	logic [11:0] quads = '0;
	logic [11:0] starve = '0;
	logic [11:0] sent;
	logic [11:0] tx_threshold_o;
	fill_t fill_i;
	drain_t drain_i;
	logic reg_rvalid_o;
	logic tx_start_o;
	logic tx_underrun_o;
	logic saf_active_o;
	logic tx_reorder_disable_o;
	logic [11:0] tbl [4] = '{12'h800, 12'h6C0, 12'h400, 12'h200};
	int bad_count = 0;
	int n_tests = 0;

	async_tx_threshold_control DUT (.clock_i, .rst_i, .reg_req_i, .reg_rdata_o, .reg_rvalid_o, .eeprom_load_i,
		.eeprom_data_i, .retry_limit_i, .retry_i, .fill_i, .drain_i, .tx_start_o, .tx_underrun_o, .saf_active_o,
		.tx_reorder_disable_o, .tx_threshold_o);
	fifo_side_model partner (.clock_i, .rst_i, .go_i(go), .quads_i(quads), .starve_i(starve),
		.tx_start_i(tx_start_o), .tx_underrun_i(tx_underrun_o), .fill_o(fill_i), .drain_o(drain_i), .sent_o(sent));

	// 250 MHz
	initial
	begin
		forever #2 clock_i = ~clock_i;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			bad_count++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic finish_test;
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// One register access; read data lands with rvalid one edge after the request
	task automatic acc(input logic w, input logic m, input logic [11:0] a, input logic [31:0] d);
		@(posedge clock_i);
		#1 reg_req_i = '{wr: w, rd: !w, mem_space: m, addr: a, wdata: d};
		@(posedge clock_i);
		#1 reg_req_i = '0;
		rd = reg_rdata_o;
		if (!w)
			chk(reg_rvalid_o, 32'h1);
	endtask

	// Bounded wait: 0 start, 1 underrun, 2 link done; a miss counts as a mismatch
	task automatic wt(input int k);
		int i;
		for (i = 0; i < 3000; i++)
		begin
			@(posedge clock_i);
			#1;
			if ((k == 0 && tx_start_o === 1'h1) || (k == 1 && tx_underrun_o === 1'h1) || (k == 2 && drain_i.done === 1'h1))
				break;
		end
		if (i == 3000)
			chk(32'hDEAD, k);
	endtask

	// Sends one packet and checks how many quadlets were in when sending began
	task automatic pkt(input logic [11:0] n, input logic [11:0] st, input logic rt, input logic [11:0] lo,
		input logic [11:0] hi, input logic ur);
		@(posedge clock_i);
		#1 quads = n;
		starve = st;
		retry_i = rt;
		go = 1'h1;
		@(posedge clock_i);
		#1 go = 1'h0;
		wt(0);
		chk(sent >= lo && sent <= hi, 32'h1);
		wt(ur ? 1 : 2);
		repeat (3) @(posedge clock_i);
		#1;
	endtask

	// Tests take a few thousand cycles; allow ten thousand
	initial
	begin
		#40000;
		bad_count++;
		finish_test;
	end

	initial
	begin
		repeat (6) @(posedge clock_i);
		#1 rst_i = 1'h0;
		chk(tx_threshold_o, 32'h6C0);
		acc(1'h0, 1'h0, 12'h0F4, '0);
		chk(rd, 32'h1000);
		chk(tx_reorder_disable_o, 32'h0);
		acc(1'h1, 1'h1, 12'h088, 32'hFFFFBFFF);
		acc(1'h0, 1'h1, 12'h088, '0);
		chk(rd, 32'hB000);
		chk(tx_reorder_disable_o, 32'h1);
		acc(1'h1, 1'h1, 12'h08C, 32'h8000);
		acc(1'h0, 1'h0, 12'h0F4, '0);
		chk(rd, 32'h3000);
		acc(1'h0, 1'h0, 12'h088, '0);
		chk(rd, 32'h0);
		for (int s = 0; s < 4; s++)
		begin
			acc(1'h1, 1'h0, 12'h0F4, s << 12);
			acc(1'h0, 1'h1, 12'h08C, '0);
			chk(tx_threshold_o, tbl[s]);
			chk(saf_active_o, s == 0);
		end
		pkt(12'd200, 12'hFFF, 1'h0, 12'd128, 12'd140, 1'h0);
		pkt(12'd10, 12'hFFF, 1'h0, 12'd10, 12'd10, 1'h0);
		pkt(12'd200, 12'hFFF, 1'h1, 12'd200, 12'd200, 1'h0);
		pkt(12'd200, 12'hFFF, 1'h0, 12'd128, 12'd140, 1'h0);
		retry_limit_i = 4'h0;
		repeat (3) @(posedge clock_i);
		#1 chk(saf_active_o, 32'h1);
		chk(tx_threshold_o, 32'h800);
		pkt(12'd200, 12'hFFF, 1'h0, 12'd200, 12'd200, 1'h0);
		retry_limit_i = 4'h1;
		repeat (3) @(posedge clock_i);
		#1 chk(tx_threshold_o, 32'h200);
		pkt(12'd300, 12'd140, 1'h0, 12'd128, 12'd140, 1'h1);
		chk(saf_active_o, 32'h1);
		chk(tx_threshold_o, 32'h800);
		pkt(12'd200, 12'hFFF, 1'h0, 12'd200, 12'd200, 1'h0);
		acc(1'h1, 1'h0, 12'h0F4, 32'h3000);
		acc(1'h0, 1'h0, 12'h0F4, '0);
		chk(tx_threshold_o, 32'h200);
		acc(1'h1, 1'h1, 12'h08C, 32'h2000);
		acc(1'h0, 1'h0, 12'h0F4, '0);
		chk(rd, 32'h1000);
		chk(tx_threshold_o, 32'h6C0);
		@(posedge clock_i);
		#1 eeprom_data_i = 32'hFFFFA000;
		eeprom_load_i = 1'h1;
		@(posedge clock_i);
		#1 eeprom_load_i = 1'h0;
		acc(1'h0, 1'h0, 12'h0F4, '0);
		chk(rd, 32'hA000);
		chk(tx_reorder_disable_o, 32'h1);
		finish_test;
	end
endmodule
